// >>> rtl/itc_pkg.sv
// Package of constants and types for the interval timer counter.
// Operation
// - A sixteen-bit free-running counter usable as interval timer or event counter.
// - Mode comes from clock source, gate and sync control bits.
// - Timer and gated timer modes count the instruction cycle clock.
// - Both counter modes count edges of the external count input pin.
// - With sync selected, the external input is synchronised after the prescaler.
// - Asynchronous counter mode also counts the synchronised input, without the post-prescaler realignment stage.
// - Clock source at bit 1, sync at bit 2, gate at bit 6.
package itc_pkg;

	localparam int          ITC_COUNT_WIDTH      = 16;
	localparam int          ITC_CTRL_WIDTH       = 16;
	localparam int          ITC_CLOCK_SOURCE_POS = 1;
	localparam int          ITC_SYNC_POS         = 2;
	localparam int          ITC_GATE_POS         = 6;
	localparam logic [15:0] ITC_COUNT_RESET      = 16'h0000;
	localparam logic [7:0]  ITC_PRESCALE_RESET   = 8'h00;
	localparam int          ITC_PRESCALE_WIDTH   = 8;

	typedef enum logic [1:0] {
		ITC_MODE_TIMER,
		ITC_MODE_GATED,
		ITC_MODE_SYNC_COUNT,
		ITC_MODE_ASYNC_COUNT
	} itc_mode_type;

endpackage : itc_pkg

// >>> rtl/itc_sync2.sv
// Two-stage synchroniser for a single level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module itc_sync2 (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic resetn_in,
	// Level
	input  wire logic d_in,
	output logic      q_out
);

	logic stage1;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stage1 <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			stage1 <= d_in;
			q_out  <= stage1;
		end
	end

endmodule : itc_sync2
`default_nettype wire

// >>> rtl/itc_timer.sv
// Sixteen-bit interval timer and event counter with four clocking modes.
`timescale 1ns/1ps
`default_nettype none
module itc_timer
	import itc_pkg::*;
#(
	parameter int COUNT_WIDTH    = ITC_COUNT_WIDTH,
	parameter int PRESCALE_WIDTH = ITC_PRESCALE_WIDTH
) (
	// Clock and reset
	input  wire logic                      clk_sys_in,
	input  wire logic                      resetn_in,
	// Control
	input  wire logic [ITC_CTRL_WIDTH-1:0] timer_control_word_in,
	input  wire logic                      timer_enable_in,
	input  wire logic [PRESCALE_WIDTH-1:0] prescale_ratio_in,
	// Pins
	input  wire logic                      external_count_input_in,
	input  wire logic                      gate_input_in,
	// Status
	output logic [COUNT_WIDTH-1:0]         count_out,
	output logic [1:0]                     mode_out,
	output logic                           count_tick_out
);

	// Reset release.
	logic                      rst_meta;
	logic                      next_rst_meta;
	logic                      rst_sync_n;
	logic                      next_rst_sync_n;

	// Synchronised pins.
	logic                      ext_sync;
	logic                      gate_sync;

	// Control decode.
	logic                      clock_source_select;
	logic                      external_sync_select;
	logic                      gate_accumulate_enable;
	itc_mode_type              mode;

	// Edge history of the count pin.
	logic                      ext_prev;
	logic                      next_ext_prev;
	logic                      ext_async_edge;
	logic                      raw_edge;
	logic                      event_taken;

	// Prescaler and tick.
	logic [PRESCALE_WIDTH-1:0] prescale;
	logic [PRESCALE_WIDTH-1:0] next_prescale;
	logic                      prescale_done;
	logic                      next_tick;
	logic                      tick_sync;
	logic                      next_tick_sync;

	// Counter and status.
	logic                      count_step;
	logic [COUNT_WIDTH-1:0]    next_count;
	logic [1:0]                next_mode_out;

	// The rest of the block only sees a reset whose release is aligned to the clock.
	always_comb begin
		next_rst_meta   = 1'b1;
		next_rst_sync_n = rst_meta;
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= next_rst_meta;
			rst_sync_n <= next_rst_sync_n;
		end
	end

	itc_sync2 u_ext_sync (
		.clk_in    (clk_sys_in),
		.resetn_in (rst_sync_n),
		.d_in      (external_count_input_in),
		.q_out     (ext_sync)
	);

	itc_sync2 u_gate_sync (
		.clk_in    (clk_sys_in),
		.resetn_in (rst_sync_n),
		.d_in      (gate_input_in),
		.q_out     (gate_sync)
	);

	assign clock_source_select    = timer_control_word_in[ITC_CLOCK_SOURCE_POS];
	assign external_sync_select   = timer_control_word_in[ITC_SYNC_POS];
	assign gate_accumulate_enable = timer_control_word_in[ITC_GATE_POS];

	// Every combination is listed, so a don't-care bit can never change the mode.
	always_comb begin
		case ({clock_source_select, external_sync_select, gate_accumulate_enable})
			3'h0:    mode = ITC_MODE_TIMER;
			3'h1:    mode = ITC_MODE_GATED;
			3'h2:    mode = ITC_MODE_TIMER;
			3'h3:    mode = ITC_MODE_GATED;
			3'h4:    mode = ITC_MODE_ASYNC_COUNT;
			3'h5:    mode = ITC_MODE_ASYNC_COUNT;
			3'h6:    mode = ITC_MODE_SYNC_COUNT;
			3'h7:    mode = ITC_MODE_SYNC_COUNT;
			default: mode = ITC_MODE_TIMER;
		endcase
	end

	always_comb begin
		case (mode)
			ITC_MODE_TIMER:       raw_edge = 1'b1;
			ITC_MODE_GATED:       raw_edge = gate_sync;
			ITC_MODE_SYNC_COUNT:  raw_edge = ext_async_edge;
			ITC_MODE_ASYNC_COUNT: raw_edge = ext_async_edge;
			default:              raw_edge = 1'b0;
		endcase
	end

	// With no second clock allowed, the asynchronous path rides the same synchronised copy.
	// It differs from sync counting only by skipping the post-prescaler realignment stage.
	assign ext_async_edge = ext_sync & ~ext_prev;

	always_comb begin
		next_ext_prev = ext_sync;
	end

	// The history resets to the idle level of the pin, so no false edge follows reset.
	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= next_ext_prev;
		end
	end

	assign event_taken   = timer_enable_in & raw_edge;
	assign prescale_done = (prescale >= prescale_ratio_in);

	// A ratio of zero gives a tick on every qualified event.
	always_comb begin
		next_prescale = prescale;
		next_tick     = 1'b0;
		if (event_taken) begin
			if (prescale_done) begin
				next_prescale = '0;
				next_tick     = 1'b1;
			end else begin
				next_prescale = PRESCALE_WIDTH'(prescale + 1'b1);
			end
		end
		// Sync mode realigns the prescaler output once more on the system clock before counting.
		next_tick_sync = next_tick & (mode == ITC_MODE_SYNC_COUNT);
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prescale <= ITC_PRESCALE_RESET[PRESCALE_WIDTH-1:0];
		end else begin
			prescale <= next_prescale;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count_tick_out <= 1'b0;
			tick_sync      <= 1'b0;
		end else begin
			count_tick_out <= next_tick;
			tick_sync      <= next_tick_sync;
		end
	end

	// A tick still in the realignment stage is dropped if the mode leaves sync counting.
	always_comb begin
		count_step = (mode == ITC_MODE_SYNC_COUNT) ? tick_sync : next_tick;
		next_count = count_out;
		if (count_step) begin
			next_count = COUNT_WIDTH'(count_out + 1'b1);
		end
	end

	// The counter wraps from all ones to zero with no flag of its own.
	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count_out <= ITC_COUNT_RESET[COUNT_WIDTH-1:0];
		end else begin
			count_out <= next_count;
		end
	end

	always_comb begin
		next_mode_out = mode;
	end

	always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode_out <= 2'h0;
		end else begin
			mode_out <= next_mode_out;
		end
	end

endmodule : itc_timer
`default_nettype wire

// >>> test/itc_ext_src.sv
// Model of the external source on the count pin.
`timescale 1ns/1ps
`default_nettype none
module itc_ext_src (
	input  wire logic clk_in,
	output var logic  pin_out
);
	initial pin_out = 1'b0;
	// Two cycles high and two low, so the synchroniser never drops a pulse.
	task automatic burst(input int n);
		repeat (n) begin
			repeat (2) @(posedge clk_in) pin_out <= 1'b1;
			repeat (2) @(posedge clk_in) pin_out <= 1'b0;
		end
	endtask : burst
endmodule : itc_ext_src
`default_nettype wire

// >>> test/itc_timer_sva.sv
// Port checks for the timer counter.
`timescale 1ns/1ps
`default_nettype none
module itc_timer_sva (
	input wire logic clk_sys_in, resetn_in, timer_enable_in, external_count_input_in, gate_input_in, count_tick_out,
	input wire logic [15:0] timer_control_word_in, count_out,
	input wire logic [7:0] prescale_ratio_in,
	input wire logic [1:0] mode_out
);
	wire [15:0] w = timer_control_word_in, c = count_out;
	wire [1:0] m = mode_out;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	property p_mode; $past(resetn_in, 3) |-> m == {$past(w[1]), $past(w[1]) ? !$past(w[2]) : $past(w[6])}; endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_step; !$stable(c) |-> c == $past(c) + 16'h0001; endproperty
	a_step: assert property (p_step) else $error("step");
	property p_tick; count_tick_out && m != 2'h2 |-> c == $past(c) + 16'h0001; endproperty
	a_tick: assert property (p_tick) else $error("tick");
	property p_timer; (m == 2'h0 && timer_enable_in && prescale_ratio_in == 8'h00)[*3] |-> !$stable(c); endproperty
	a_timer: assert property (p_timer) else $error("timer");
	property p_gate; (m == 2'h1 && !gate_input_in)[*6] |-> $stable(c); endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_idle; (m[1] && !external_count_input_in)[*7] |-> $stable(c); endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_sync; m == 2'h2 && timer_enable_in && $rose(external_count_input_in) |-> ##[1:5] !$stable(c); endproperty
	a_sync: assert property (p_sync) else $error("sync");
	property p_async; m == 2'h3 && timer_enable_in && $rose(external_count_input_in) |-> ##[1:4] !$stable(c); endproperty
	a_async: assert property (p_async) else $error("async");
endmodule : itc_timer_sva
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the timer counter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ck = 1'b0, rn = 1'b0, en = 1'b0, gt = 1'b0, pin, tk;
	logic [7:0] pr = 8'h00;
	int ticks = 0;
	logic [15:0] cw = 16'h0000, cnt, ec = 16'h0000;
	logic [1:0] md;
	logic [17:0] q[$];
	int fail_count = 0, comparisons = 0, seed = 32'h77A965C0;
	event look;
	initial forever #25 ck = ~ck;
	itc_timer itc_timer_i (.clk_sys_in(ck), .resetn_in(rn), .timer_control_word_in(cw), .timer_enable_in(en),
		.prescale_ratio_in(pr), .external_count_input_in(pin), .gate_input_in(gt), .count_out(cnt),
		.mode_out(md), .count_tick_out(tk));
	always @(negedge ck) if (tk === 1'b1) ticks++;
	itc_ext_src itc_ext_src_i (.clk_in(ck), .pin_out(pin));
	task automatic check(input string s, input logic [15:0] v, x);
		comparisons++;
		if (v !== x) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", s, x, v);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d fails %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// Timer mode sees 5n+7 cycles, one tick per ratio plus one; the other modes see n events.
	task automatic run(input logic [1:0] m, input int n, input logic e, input logic [7:0] r);
		@(negedge ck) cw = 16'($random(seed));
		pr = r;
		cw[1] = m[1];
		if (m[1]) cw[2] = !m[0];
		else cw[6] = m[0];
		repeat (2) @(negedge ck);
		en = e;
		gt = 1'b1;
		repeat (n) @(negedge ck);
		gt = 1'b0;
		itc_ext_src_i.burst(n);
		repeat (8) @(negedge ck);
		en = 1'b0;
		repeat (8) @(negedge ck);
		ec += !e ? 16'h0000 : m == 2'h0 ? 16'((5 * n + 7) / (r + 1)) : 16'(n);
		q.push_back({m, ec});
		->look;
		$display("run %0d done", m);
	endtask : run
	initial forever begin
		@(look);
		check("count", cnt, q[0][15:0]);
		check("mode", {14'h0, md}, {14'h0, q[0][17:16]});
		check("ticks", 16'(ticks), q[0][15:0]);
		void'(q.pop_front());
	end
	initial begin
		repeat (2) @(negedge ck);
		rn = 1'b1;
		repeat (4) @(negedge ck);
		for (int i = 0; i < 8; i++) run(i[2:1], 1 + ($random(seed) & 7), !i[0], 8'h00);
		run(2'h0, 1 + ($random(seed) & 7), 1'b1, 8'h02);
		run(2'h0, 13106, 1'b1, 8'h00);
		@(negedge ck);
		give_verdict();
	end
	initial begin
		#4000000;
		fail_count++;
		give_verdict();
	end
endmodule : tb_top
bind itc_timer itc_timer_sva itc_timer_sva_i (.*);
`default_nettype wire
